// [hw/dad_decoder.sv]
`default_nettype none
module dad_decoder (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic branchInputPin,
   output logic [5:0] execOp,
   output logic execValid,
   output logic [4:0] execShift,
   output logic [7:0] execAddr,
   output logic [15:0] execImm,
   output logic [1:0] execCycles,
   output logic execVarCycles,
   output logic condMet
);
   logic [1:0] rstSync_r;
   logic rstN;
   logic waitReq_r;
   logic [31:0] readData_r;
   logic [15:0] instr_r;
   logic [15:0] operand_r;
   logic [31:0] primary_r;
   logic [2:0] flags_r;
   logic [9:0] cond_r;
   logic [4:0] temp_r;
   logic pending_r;
   logic valid_r;
   dad_pkg::dad_op_t op_r;
   logic [4:0] shift_r;
   logic [1:0] cyc_r;
   logic varCyc_r;
   logic condMet_r;
   logic selMet_r;
   logic execValid_r;

   // synchroniser: second stage is the only reader of the first
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync_r <= 2'h0;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   assign rstN = rstSync_r[1];

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic dad_pkg::dad_op_t decodeOp(input logic [15:0] w);
      dad_pkg::dad_op_t o;
      o = dad_pkg::OP_NONE;
      casez (w)
         16'hBE00: o = dad_pkg::OP_MAG;
         16'b0010_????_????_????: o = dad_pkg::OP_ADD_SHF;
         16'b1011_1000_????_????: o = dad_pkg::OP_ADD_SHORT;
         16'b0110_0001_????_????: o = dad_pkg::OP_ADD_16;
         16'b1011_1111_1001_????: o = dad_pkg::OP_ADD_LONG;
         16'b0110_0000_????_????: o = dad_pkg::OP_SUM_CARRY;
         16'b0110_0010_????_????: o = dad_pkg::OP_SUM_NOSX;
         16'b0110_0011_????_????: o = dad_pkg::OP_SUM_TEMP;
         16'hBE10: o = dad_pkg::OP_BK_SUM;
         16'hBE11: o = dad_pkg::OP_BK_SUM_C;
         16'hBE18: o = dad_pkg::OP_BK_DIFF;
         16'hBE19: o = dad_pkg::OP_BK_DIFF_B;
         16'hBE1B: o = dad_pkg::OP_KEEP_GT;
         16'hBE1C: o = dad_pkg::OP_KEEP_LT;
         16'hBE1D: o = dad_pkg::OP_SWAP;
         16'hBE1F: o = dad_pkg::OP_RESTORE;
         16'hBE1E: o = dad_pkg::OP_SAVE;
         16'b0001_????_????_????: o = dad_pkg::OP_LOAD_SHF;
         16'b0110_1010_????_????: o = dad_pkg::OP_LOAD_16;
         16'b1011_1111_1000_????: o = dad_pkg::OP_LOAD_LONG;
         16'b1011_1001_????_????: o = dad_pkg::OP_LOADLO_IMM;
         16'b0110_1001_????_????: o = dad_pkg::OP_LOADLO_MEM;
         16'b0110_1011_????_????: o = dad_pkg::OP_LOAD_TEMP;
         16'b0000_1000_????_????: o = dad_pkg::OP_LOAD_MAPPED;
         16'b1000_1000_????_????: o = dad_pkg::OP_STORE_MAPPED;
         16'b0110_1110_????_????: o = dad_pkg::OP_AND_MEM;
         16'b0110_1101_????_????: o = dad_pkg::OP_OR_MEM;
         16'hBE12: o = dad_pkg::OP_AND_BK;
         16'b1011_1111_1100_????: o = dad_pkg::OP_OR_LONG;
         16'hBE82: o = dad_pkg::OP_OR_LONG16;
         16'b1011_1111_1110_????: o = dad_pkg::OP_BARREL_R;
         16'hBE0C: o = dad_pkg::OP_ROT_L;
         16'hBE14: o = dad_pkg::OP_PAIR_ROT_L;
         16'hBE09: o = dad_pkg::OP_SHL;
         16'hBE0A: o = dad_pkg::OP_SHR;
         16'hBE16: o = dad_pkg::OP_PAIR_SHL;
         16'hBE17: o = dad_pkg::OP_PAIR_SHR;
         16'hBE5A: o = dad_pkg::OP_TEMPCTL_HI;
         16'hBE5B: o = dad_pkg::OP_TEMPCTL_LO;
         16'b0011_????_????_????: o = dad_pkg::OP_SUB_SHF;
         16'b1011_1010_????_????: o = dad_pkg::OP_SUB_SHORT;
         16'b1011_1111_1010_????: o = dad_pkg::OP_SUB_LONG;
         16'b1001_1???_????_????: o = dad_pkg::OP_STORE_HI;
         default: o = dad_pkg::OP_NONE;
      endcase
      return o;
   endfunction

   function automatic logic isLong(input dad_pkg::dad_op_t o);
      logic l;
      case (o)
         dad_pkg::OP_ADD_LONG,
         dad_pkg::OP_LOAD_LONG,
         dad_pkg::OP_OR_LONG,
         dad_pkg::OP_OR_LONG16,
         dad_pkg::OP_SUB_LONG: l = 1'b1;
         default: l = 1'b0;
      endcase
      return l;
   endfunction

   // bus decode
   wire accept = (avs_read || avs_write) && waitReq_r;
   wire wrAccept = accept && avs_write;
   wire hitInstr = avs_address == dad_pkg::OFS_INSTR;
   wire hitOperand = avs_address == dad_pkg::OFS_OPERAND;
   wire hitPrimary = avs_address == dad_pkg::OFS_PRIMARY;
   wire hitFlags = avs_address == dad_pkg::OFS_FLAGS;
   wire hitCond = avs_address == dad_pkg::OFS_COND;
   wire hitTemp = avs_address == dad_pkg::OFS_TEMP;
   wire hitDecode = avs_address == dad_pkg::OFS_DECODE;
   wire [31:0] instrMerged = mergeBytes({16'h0000, instr_r}, avs_writedata,
                                        avs_byteenable);
   wire [31:0] operandMerged = mergeBytes({16'h0000, operand_r}, avs_writedata,
                                          avs_byteenable);
   wire [31:0] primaryMerged = mergeBytes(primary_r, avs_writedata, avs_byteenable);
   wire [31:0] flagsMerged = mergeBytes({29'h0, flags_r}, avs_writedata, avs_byteenable);
   wire [31:0] condMerged = mergeBytes({22'h0, cond_r}, avs_writedata, avs_byteenable);
   wire [31:0] tempMerged = mergeBytes({27'h0, temp_r}, avs_writedata, avs_byteenable);
   wire instrWr = wrAccept && hitInstr;
   wire operandWr = wrAccept && hitOperand;

   // decode of the newly written word
   wire [15:0] newWord = instrMerged[15:0];
   wire dad_pkg::dad_op_t newOp = decodeOp(newWord);
   wire newLong = isLong(newOp);
   wire newVar = (newOp == dad_pkg::OP_LOAD_MAPPED) ||
                 (newOp == dad_pkg::OP_STORE_MAPPED);
   wire [1:0] newCyc = newLong ? dad_pkg::CYC_TWO : dad_pkg::CYC_ONE;
   // temp-driven shifts are sampled when the word is written
   logic [4:0] newShift;
   always_comb begin
      case (newOp)
         dad_pkg::OP_ADD_SHF, dad_pkg::OP_LOAD_SHF,
         dad_pkg::OP_SUB_SHF: newShift = {1'b0, newWord[11:8]};
         dad_pkg::OP_ADD_LONG, dad_pkg::OP_LOAD_LONG, dad_pkg::OP_OR_LONG,
         dad_pkg::OP_SUB_LONG, dad_pkg::OP_BARREL_R: newShift = {1'b0, newWord[3:0]};
         dad_pkg::OP_STORE_HI: newShift = {2'h0, newWord[10:8]};
         dad_pkg::OP_ADD_16, dad_pkg::OP_LOAD_16,
         dad_pkg::OP_OR_LONG16: newShift = dad_pkg::SHIFT_16;
         dad_pkg::OP_SUM_TEMP, dad_pkg::OP_LOAD_TEMP,
         dad_pkg::OP_TEMPCTL_LO: newShift = {1'b0, temp_r[3:0]};
         dad_pkg::OP_TEMPCTL_HI: newShift = temp_r[4] ? dad_pkg::SHIFT_0 :
                                                      dad_pkg::SHIFT_16;
         default: newShift = dad_pkg::SHIFT_0;
      endcase
   end

   // condition evaluation
   wire zeroF = primary_r == 32'h0000_0000;
   wire negF = primary_r[31];
   wire [3:0] flagVec = {zeroF, negF, flags_r[dad_pkg::FLG_OVF],
                         flags_r[dad_pkg::FLG_CARRY]};
   wire [3:0] mask = cond_r[3:0];
   wire [3:0] wantState = cond_r[dad_pkg::CND_STATE_LSB +: 4];
   // a tested flag matches when it equals its wanted state
   wire [3:0] matchVec = ~(flagVec ^ wantState);
   wire condNow = |(mask & matchVec);
   wire [1:0] selPair = cond_r[dad_pkg::CND_SEL_LSB +: 2];
   wire testF = flags_r[dad_pkg::FLG_TEST];
   logic selNow;
   always_comb begin
      case (selPair)
         dad_pkg::SEL_PIN_LOW: selNow = ~branchInputPin;
         dad_pkg::SEL_TEST_SET: selNow = testF;
         dad_pkg::SEL_TEST_CLR: selNow = ~testF;
         default: selNow = 1'b0;
      endcase
   end

   // decode status word, field order matches the package positions
   wire [31:0] decodeWord = {5'h00,
                             selMet_r,
                             condMet_r,
                             instr_r[7:0],
                             shift_r,
                             valid_r,
                             pending_r,
                             varCyc_r,
                             cyc_r,
                             isLong(op_r),
                             6'(op_r)};
   wire [31:0] rdMux = hitInstr ? {16'h0000, instr_r} :
                       hitOperand ? {16'h0000, operand_r} :
                       hitPrimary ? primary_r :
                       hitFlags ? {29'h0, flags_r} :
                       hitCond ? {22'h0, cond_r} :
                       hitTemp ? {27'h0, temp_r} :
                       hitDecode ? decodeWord : 32'h0000_0000;
   // a two-word op fires only when its operand arrives
   wire fireNow = (instrWr && !newLong) || (operandWr && pending_r);
   // issue fields come from the new word for one-word ops, else from the held word, with the immediate taken from the operand write
   wire [5:0] execOpNxt = instrWr ? 6'(newOp) : 6'(op_r);
   wire [4:0] execShiftNxt = instrWr ? newShift : shift_r;
   wire [7:0] execAddrNxt = instrWr ? newWord[7:0] : instr_r[7:0];
   wire [15:0] execImmNxt = instrWr ? {8'h00, newWord[7:0]} : operandMerged[15:0];
   wire [1:0] execCyclesNxt = instrWr ? newCyc : cyc_r;
   wire execVarNxt = instrWr ? newVar : varCyc_r;

   // bus handshake: one cycle low waitrequest per request
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         waitReq_r <= 1'b1;
      end else begin
         waitReq_r <= !accept;
      end
   end

   // read data holds until the next read is taken
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         readData_r <= dad_pkg::RST_WORD;
      end else if (accept && avs_read) begin
         readData_r <= rdMux;
      end
   end

   // byte lanes merge so a partial write leaves the other lanes alone
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         operand_r <= 16'h0000;
      end else if (operandWr) begin
         operand_r <= operandMerged[15:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         primary_r <= dad_pkg::RST_WORD;
      end else if (wrAccept && hitPrimary) begin
         primary_r <= primaryMerged;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         flags_r <= 3'h0;
      end else if (wrAccept && hitFlags) begin
         flags_r <= flagsMerged[2:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         cond_r <= 10'h000;
      end else if (wrAccept && hitCond) begin
         cond_r <= condMerged[9:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         temp_r <= 5'h00;
      end else if (wrAccept && hitTemp) begin
         temp_r <= tempMerged[4:0];
      end
   end

   // pending clears when the operand arrives; a new instruction word restarts it
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         pending_r <= 1'b0;
      end else if (instrWr) begin
         pending_r <= newLong;
      end else if (operandWr) begin
         pending_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         instr_r <= 16'h0000;
         op_r <= dad_pkg::OP_NONE;
         shift_r <= dad_pkg::SHIFT_0;
         cyc_r <= dad_pkg::CYC_ONE;
         varCyc_r <= 1'b0;
         valid_r <= 1'b0;
      end else if (instrWr) begin
         instr_r <= newWord;
         op_r <= newOp;
         shift_r <= newShift;
         cyc_r <= newCyc;
         varCyc_r <= newVar;
         valid_r <= newOp != dad_pkg::OP_NONE;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         condMet_r <= 1'b0;
         selMet_r <= 1'b0;
         execValid_r <= 1'b0;
         execOp <= 6'h00;
         execShift <= dad_pkg::SHIFT_0;
         execAddr <= 8'h00;
         execImm <= 16'h0000;
         execCycles <= dad_pkg::CYC_ONE;
         execVarCycles <= 1'b0;
      end else begin
         condMet_r <= condNow;
         selMet_r <= selNow;
         execValid_r <= fireNow;
         if (fireNow) begin
            execOp <= execOpNxt;
            execShift <= execShiftNxt;
            execAddr <= execAddrNxt;
            execImm <= execImmNxt;
            execCycles <= execCyclesNxt;
            execVarCycles <= execVarNxt;
         end
      end
   end

   assign avs_waitrequest = waitReq_r;
   assign avs_readdata = readData_r;
   assign execValid = execValid_r;
   assign condMet = condMet_r;
endmodule // dad_decoder
`default_nettype wire

// [hw/dad_pkg.sv]
`default_nettype none
package dad_pkg;
   // register byte offsets on the avalon slave
   localparam logic [4:0] OFS_INSTR = 5'h00;
   localparam logic [4:0] OFS_OPERAND = 5'h04;
   localparam logic [4:0] OFS_PRIMARY = 5'h08;
   localparam logic [4:0] OFS_FLAGS = 5'h0C;
   localparam logic [4:0] OFS_DECODE = 5'h10;
   localparam logic [4:0] OFS_COND = 5'h14;
   localparam logic [4:0] OFS_TEMP = 5'h18;
   // flags register bit positions
   localparam int FLG_CARRY = 0;
   localparam int FLG_OVF = 1;
   localparam int FLG_TEST = 2;
   // decode status field positions
   localparam int DEC_OP_LSB = 0;
   localparam int DEC_WORDS = 6;
   localparam int DEC_CYC_LSB = 7;
   localparam int DEC_VARCYC = 9;
   localparam int DEC_PEND = 10;
   localparam int DEC_VALID = 11;
   localparam int DEC_SHIFT_LSB = 12;
   localparam int DEC_ADDR_LSB = 17;
   localparam int DEC_CONDMET = 25;
   localparam int DEC_SELMET = 26;
   // condition word fields
   localparam int CND_STATE_LSB = 4;
   localparam int CND_SEL_LSB = 8;
   localparam logic [1:0] SEL_PIN_LOW = 2'h0;
   localparam logic [1:0] SEL_TEST_SET = 2'h1;
   localparam logic [1:0] SEL_TEST_CLR = 2'h2;
   // cycle counts and shift constants
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [4:0] SHIFT_16 = 5'h10;
   localparam logic [4:0] SHIFT_0 = 5'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [5:0] {
      OP_NONE, OP_MAG, OP_ADD_SHF, OP_ADD_SHORT, OP_ADD_LONG, OP_ADD_16,
      OP_SUM_CARRY, OP_SUM_NOSX, OP_SUM_TEMP, OP_BK_SUM, OP_BK_SUM_C,
      OP_BK_DIFF, OP_BK_DIFF_B, OP_KEEP_GT, OP_KEEP_LT, OP_SWAP,
      OP_RESTORE, OP_SAVE, OP_LOAD_SHF, OP_LOAD_LONG, OP_LOAD_16,
      OP_LOADLO_IMM, OP_LOADLO_MEM, OP_LOAD_TEMP, OP_LOAD_MAPPED,
      OP_STORE_MAPPED, OP_AND_MEM, OP_OR_MEM, OP_AND_BK, OP_OR_LONG,
      OP_OR_LONG16, OP_BARREL_R, OP_ROT_L, OP_PAIR_ROT_L, OP_SHL, OP_SHR,
      OP_PAIR_SHL, OP_PAIR_SHR, OP_TEMPCTL_HI, OP_TEMPCTL_LO, OP_SUB_SHF,
      OP_SUB_SHORT, OP_SUB_LONG, OP_STORE_HI
   } dad_op_t;
endpackage
`default_nettype wire

// [tb/dad_decoder_properties.sv]
`default_nettype none
module dad_decoder_checker (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic branchInputPin,
   input wire logic [5:0] execOp,
   input wire logic execValid,
   input wire logic [4:0] execShift,
   input wire logic [7:0] execAddr,
   input wire logic [15:0] execImm,
   input wire logic [1:0] execCycles,
   input wire logic execVarCycles,
   input wire logic condMet
);
   // last instruction word taken, so issued fields can be tied to their cause
   logic [15:0] instrW;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         instrW <= 16'h0000;
      end else if (avs_write && avs_waitrequest && avs_address == dad_pkg::OFS_INSTR) begin
         instrW <= avs_writedata[15:0];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wait_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   answer_next_a: assert property
      ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered in the next cycle");
   valid_cause_a: assert property
      (execValid |-> $past(avs_write && avs_waitrequest))
      else $error("op issued without a taken write");
   valid_single_a: assert property (execValid |=> !execValid)
      else $error("issue pulse longer than one cycle");
   two_cycle_ops_a: assert property
      (execValid |-> ((execCycles == dad_pkg::CYC_TWO) ==
      (execOp inside {dad_pkg::OP_ADD_LONG, dad_pkg::OP_LOAD_LONG, dad_pkg::OP_OR_LONG,
      dad_pkg::OP_OR_LONG16, dad_pkg::OP_SUB_LONG})))
      else $error("cycle count wrong for op");
   var_cycle_ops_a: assert property
      (execValid |-> (execVarCycles ==
      (execOp inside {dad_pkg::OP_LOAD_MAPPED, dad_pkg::OP_STORE_MAPPED})))
      else $error("variable cycle flag wrong for op");
   addr_pass_a: assert property
      (execValid |-> execAddr == instrW[7:0])
      else $error("low byte not passed unchanged");
   shift_field_a: assert property
      (execValid && (execOp inside {dad_pkg::OP_ADD_SHF,
      dad_pkg::OP_LOAD_SHF, dad_pkg::OP_SUB_SHF}) |-> execShift == {1'b0, instrW[11:8]})
      else $error("four bit shift field wrong");
   store_shift_a: assert property
      (execValid && execOp == dad_pkg::OP_STORE_HI |-> execShift == {2'b00, instrW[10:8]})
      else $error("three bit shift field wrong");
   long_operand_a: assert property
      (execValid && execCycles == dad_pkg::CYC_TWO |->
      $past(avs_address) == dad_pkg::OFS_OPERAND && execImm == $past(avs_writedata[15:0]))
      else $error("long operand not taken from operand word");
   mag_decode_a: assert property
      (execValid && instrW == 16'hBE00 |->
      execOp == dad_pkg::OP_MAG && execCycles == dad_pkg::CYC_ONE)
      else $error("magnitude op wrong");
endmodule // dad_decoder_checker
bind dad_decoder dad_decoder_checker chk (.sys_clk(sys_clk), .nrst(nrst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .branchInputPin(branchInputPin), .execOp(execOp), .execValid(execValid),
   .execShift(execShift), .execAddr(execAddr), .execImm(execImm),
   .execCycles(execCycles), .execVarCycles(execVarCycles), .condMet(condMet));
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, execValid, execVarCycles, condMet;
   logic branchInputPin = 1'b0;
   logic [5:0] execOp, lastOp;
   logic [4:0] execShift;
   logic [7:0] execAddr;
   logic [15:0] execImm, lastImm;
   logic [1:0] execCycles;
   int n_errors = 0;
   int check_count = 0;
   int nValid = 0;
   logic [15:0] opw [44] = '{16'hBE00, 16'h2512, 16'hB8A5, 16'h6181, 16'h6003, 16'h6204,
      16'h6305, 16'hBE10, 16'hBE11, 16'hBE18, 16'hBE19, 16'hBE1B, 16'hBE1C, 16'hBE1D,
      16'hBE1F, 16'hBE1E, 16'h1F7F, 16'h6A10, 16'hB9FF, 16'h6911, 16'h6B12, 16'h0813,
      16'h8814, 16'h6E15, 16'h6D16, 16'hBE12, 16'hBFE7, 16'hBE0C, 16'hBE14, 16'hBE09,
      16'hBE0A, 16'hBE16, 16'hBE17, 16'hBE5A, 16'hBE5B, 16'h3A20, 16'hBA21, 16'h9D22,
      16'hBF93, 16'hBF84, 16'hBFC6, 16'hBE82, 16'hBFA1, 16'hBE01};
   dad_pkg::dad_op_t ope [44] = '{dad_pkg::OP_MAG, dad_pkg::OP_ADD_SHF, dad_pkg::OP_ADD_SHORT,
      dad_pkg::OP_ADD_16, dad_pkg::OP_SUM_CARRY, dad_pkg::OP_SUM_NOSX, dad_pkg::OP_SUM_TEMP,
      dad_pkg::OP_BK_SUM, dad_pkg::OP_BK_SUM_C, dad_pkg::OP_BK_DIFF, dad_pkg::OP_BK_DIFF_B,
      dad_pkg::OP_KEEP_GT, dad_pkg::OP_KEEP_LT, dad_pkg::OP_SWAP, dad_pkg::OP_RESTORE,
      dad_pkg::OP_SAVE, dad_pkg::OP_LOAD_SHF, dad_pkg::OP_LOAD_16, dad_pkg::OP_LOADLO_IMM,
      dad_pkg::OP_LOADLO_MEM, dad_pkg::OP_LOAD_TEMP, dad_pkg::OP_LOAD_MAPPED,
      dad_pkg::OP_STORE_MAPPED, dad_pkg::OP_AND_MEM, dad_pkg::OP_OR_MEM, dad_pkg::OP_AND_BK,
      dad_pkg::OP_BARREL_R, dad_pkg::OP_ROT_L, dad_pkg::OP_PAIR_ROT_L, dad_pkg::OP_SHL,
      dad_pkg::OP_SHR, dad_pkg::OP_PAIR_SHL, dad_pkg::OP_PAIR_SHR, dad_pkg::OP_TEMPCTL_HI,
      dad_pkg::OP_TEMPCTL_LO, dad_pkg::OP_SUB_SHF, dad_pkg::OP_SUB_SHORT, dad_pkg::OP_STORE_HI,
      dad_pkg::OP_ADD_LONG, dad_pkg::OP_LOAD_LONG, dad_pkg::OP_OR_LONG, dad_pkg::OP_OR_LONG16,
      dad_pkg::OP_SUB_LONG, dad_pkg::OP_NONE};
   dad_decoder dut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .branchInputPin(branchInputPin), .execOp(execOp), .execValid(execValid),
      .execShift(execShift), .execAddr(execAddr), .execImm(execImm),
      .execCycles(execCycles), .execVarCycles(execVarCycles), .condMet(condMet));
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   // the issue pulse lasts one cycle, so it is caught here rather than in the tasks
   always @(posedge sys_clk) begin
      if (execValid === 1'b1) begin
         nValid <= nValid + 1;
         lastImm <= execImm;
         lastOp <= execOp;
      end
   end
   task automatic wrap_up;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int i;
      i = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge sys_clk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 40);
      q = avs_readdata;
      if (avs_waitrequest !== 1'b0) begin
         n_errors++;
         wrap_up();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // idle edge keeps each strobe from being driven twice in one time step
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0000_0000, q);
   endtask
   function automatic int esh(logic [15:0] w);
      if (w[15:14] == 2'b00 && w[15:12] != 4'h0) return w[11:8];
      if (w[15:11] == 5'h13) return w[10:8];
      if (w[15:8] == 8'hBF) return w[3:0];
      if (w == 16'hBE82 || w == 16'hBE5A || w[15:8] == 8'h61 || w[15:8] == 8'h6A) return 16;
      if (w == 16'hBE5B || w[15:8] == 8'h63 || w[15:8] == 8'h6B) return 7;
      return -1;
   endfunction
   task automatic t_reset;
      logic [31:0] q;
      nrst <= 1'b0;
      repeat (12) @(posedge sys_clk);
      `CHK("waitrequest", 1'b1, avs_waitrequest)
      `CHK("valid", 1'b0, execValid)
      `CHK("cycles", dad_pkg::CYC_ONE, execCycles)
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(dad_pkg::OFS_INSTR, q);
      `CHK("instr", dad_pkg::RST_WORD, q)
   endtask
   task automatic t_regs;
      logic [31:0] q;
      wr(5'h1C, 32'hFFFF_FFFF);
      rd(5'h1C, q);
      `CHK("unmapped", 32'h0000_0000, q)
      wr(dad_pkg::OFS_PRIMARY, 32'h8765_4321);
      rd(dad_pkg::OFS_PRIMARY, q);
      `CHK("primary", 32'h8765_4321, q)
   endtask
   task automatic t_ops;
      logic [31:0] q;
      logic [1:0] ec;
      logic two;
      int s, n;
      wr(dad_pkg::OFS_TEMP, 32'h0000_0007);
      for (int i = 0; i < 44; i++) begin
         two = i >= 38 && i <= 42;
         ec = two ? dad_pkg::CYC_TWO : dad_pkg::CYC_ONE;
         n = nValid;
         wr(dad_pkg::OFS_INSTR, {16'h0000, opw[i]});
         rd(dad_pkg::OFS_DECODE, q);
         `CHK("op", ope[i], q[5:0])
         `CHK("words", two, q[dad_pkg::DEC_WORDS])
         `CHK("cycles", ec, q[dad_pkg::DEC_CYC_LSB +: 2])
         `CHK("varcyc", (i == 21 || i == 22), q[dad_pkg::DEC_VARCYC])
         `CHK("known", (i != 43), q[dad_pkg::DEC_VALID])
         `CHK("lowbyte", opw[i][7:0], q[dad_pkg::DEC_ADDR_LSB +: 8])
         s = esh(opw[i]);
         if (s >= 0) `CHK("shift", 5'(s), q[dad_pkg::DEC_SHIFT_LSB +: 5])
         `CHK("pending", two, q[dad_pkg::DEC_PEND])
         if (two) begin
            `CHK("early", n, nValid)
            wr(dad_pkg::OFS_OPERAND, 32'h0000_A500 + i);
            `CHK("imm", (16'hA500 + 16'(i)), lastImm)
         end
         `CHK("issued", n + 1, nValid)
         `CHK("lastop", ope[i], lastOp)
      end
   endtask
   task automatic t_cond;
      logic [31:0] q, p;
      logic [3:0] fz, msk, st;
      logic [2:0] fl;
      logic [1:0] sel;
      logic em, es;
      for (int i = 0; i < 16; i++) begin
         p = (i % 3 == 0) ? 32'h0 : ((i % 3 == 1) ? 32'h8000_0000 : 32'h0000_0005);
         fl = 3'(i * 5);
         msk = 4'(i * 7 + 3);
         st = 4'(i * 3);
         sel = 2'(i);
         branchInputPin <= i[3];
         fz = {p == 32'h0, p[31], fl[dad_pkg::FLG_OVF], fl[dad_pkg::FLG_CARRY]};
         em = |(msk & ~(fz ^ st));
         es = (sel == 2'h0) ? !i[3] : ((sel == 2'h1) ? fl[2] : (sel == 2'h2) && !fl[2]);
         wr(dad_pkg::OFS_PRIMARY, p);
         wr(dad_pkg::OFS_FLAGS, {29'h0, fl});
         wr(dad_pkg::OFS_COND, {22'h0, sel, st, msk});
         rd(dad_pkg::OFS_DECODE, q);
         `CHK("condmet", em, q[dad_pkg::DEC_CONDMET])
         `CHK("condpin", em, condMet)
         `CHK("selmet", es, q[dad_pkg::DEC_SELMET])
      end
   endtask
   initial begin
      t_reset();
      t_regs();
      t_ops();
      t_cond();
      t_reset();
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
